//--- logic/ebc_defines.vh
// shared constants of the emulator break control
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH

// halt cause codes
`define EBC_CAUSE_NONE    2'h0
`define EBC_CAUSE_HW_BP   2'h1
`define EBC_CAUSE_FORCED  2'h2
`define EBC_CAUSE_TRIGGER 2'h3

// trigger edge select values
`define EBC_EDGE_RISING   1'h0
`define EBC_EDGE_FALLING  1'h1

// reset values
`define EBC_RST_COUNT     8'h00
`define EBC_RST_ADDR      12'h000

// synchroniser depth for the trigger pin
`define EBC_SYNC_STAGES   3

`endif

//--- logic/ebc_trig_edge.v
// trigger pin synchroniser, debounce and edge detector
`timescale 1ns/1ps
`include "ebc_defines.vh"

module ebc_trig_edge (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_ce,
  input  wire i_pin,
  output reg  o_rise,
  output reg  o_fall
);

  reg [`EBC_SYNC_STAGES-1:0] sync_q;
  reg                        level_q;
  wire                       stable;
  wire                       new_level;

  // stages 2 and 3 agree: the change counts
  assign stable    = (sync_q[1] == sync_q[2]);
  assign new_level = sync_q[2];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_q  <= {`EBC_SYNC_STAGES{1'b0}};
      level_q <= 1'b0;
      o_rise  <= 1'b0;
      o_fall  <= 1'b0;
    end else if (i_ce) begin
      sync_q <= {sync_q[1:0], i_pin};
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (stable && (new_level != level_q)) begin
        level_q <= new_level;
        o_rise  <= new_level;
        o_fall  <= ~new_level;
      end
    end
  end

endmodule // ebc_trig_edge

//--- logic/ebc_break_ctrl.v
// break control: hardware, pass-count, forced and trigger breaks
// How it works
// - no breakpoint halt inside a chained run
// - breakpoint halt at fetch ending the run
// - forced and trigger breaks halt mid-run
// - skipped instruction breakpoints never halt
// - pass count decrements only on execution
// - trigger break on selected pin edge
// - trace and break share one trigger
`timescale 1ns/1ps
`include "ebc_defines.vh"

module ebc_break_ctrl #(
  parameter AW  = 12,
  parameter CW  = 8,
  parameter NBP = 8,
  parameter IW  = 3
) (
  input  wire          i_clk,
  input  wire          i_rst_n,
  input  wire          i_ce,
  input  wire          i_run_cmd,
  input  wire          i_run_with_breaks_cmd,
  input  wire [AW-1:0] i_start_addr,
  input  wire          i_force_break,
  input  wire          i_trig_pin,
  input  wire          i_trig_edge_sel,
  input  wire          i_trig_break_en,
  input  wire          i_trig_trace_en,
  input  wire          i_bp_wr,
  input  wire [IW-1:0] i_bp_idx,
  input  wire          i_bp_valid,
  input  wire [AW-1:0] i_bp_addr,
  input  wire [CW-1:0] i_bp_count,
  input  wire          i_fetch,
  input  wire [AW-1:0] i_fetch_addr,
  input  wire          i_fetch_chained,
  input  wire          i_fetch_skipped,
  output reg           o_running,
  output reg           o_halt,
  output reg  [1:0]    o_halt_cause,
  output reg  [AW-1:0] o_halt_addr,
  output reg  [AW-1:0] o_resume_addr,
  output reg  [AW-1:0] o_pc_start,
  output reg           o_trace_trig
);

  reg          bp_valid_q [0:NBP-1];
  reg [AW-1:0] bp_addr_q  [0:NBP-1];
  reg [CW-1:0] bp_count_q [0:NBP-1];

  reg          breaks_en_q;
  reg          bp_pend_q;
  reg          ext_pend_q;
  reg  [1:0]   ext_cause_q;

  wire         trig_rise;
  wire         trig_fall;
  wire         trig_edge;
  wire         start;
  wire         exec_fetch;
  wire [NBP-1:0] hit;
  wire [NBP-1:0] halt_vec;
  wire [NBP-1:0] dec_vec;
  wire         any_halt_hit;
  wire         ext_halt;
  wire         bp_halt;
  wire         do_halt;

  ebc_trig_edge u_trig (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_pin   (i_trig_pin),
    .o_rise  (trig_rise),
    .o_fall  (trig_fall)
  );

  // one edge feeds trace and break
  assign trig_edge = (i_trig_edge_sel == `EBC_EDGE_FALLING) ? trig_fall : trig_rise;

  assign start = i_run_cmd | i_run_with_breaks_cmd;

  assign exec_fetch = o_running & i_fetch & ~i_fetch_skipped;

  // pass count used up
  function count_spent;
    input [CW-1:0] cnt;
    begin
      count_spent = (cnt == {CW{1'b0}});
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NBP; g = g + 1) begin : g_match
      assign hit[g]      = exec_fetch & breaks_en_q & bp_valid_q[g] & (bp_addr_q[g] == i_fetch_addr);
      assign halt_vec[g] = hit[g] & count_spent(bp_count_q[g]);
      assign dec_vec[g]  = hit[g] & ~count_spent(bp_count_q[g]);
    end
  endgenerate

  assign any_halt_hit = |halt_vec;

  // breakpoint table and pass counters
  integer i;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (i = 0; i < NBP; i = i + 1) begin
        bp_valid_q[i] <= 1'b0;
        bp_addr_q[i]  <= {AW{1'b0}};
        bp_count_q[i] <= {CW{1'b0}};
      end
    end else if (i_ce) begin
      for (i = 0; i < NBP; i = i + 1) begin
        if (i_bp_wr && (i_bp_idx == i[IW-1:0])) begin
          bp_valid_q[i] <= i_bp_valid;
          bp_addr_q[i]  <= i_bp_addr;
          bp_count_q[i] <= i_bp_count;
        end else if (dec_vec[i]) begin
          bp_count_q[i] <= bp_count_q[i] - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // trace pulse on the selected edge
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_trace_trig <= 1'b0;
    end else if (i_ce) begin
      o_trace_trig <= i_trig_trace_en & trig_edge;
    end
  end

  // halt at this fetch, external request first
  assign ext_halt = o_running & i_fetch & ext_pend_q;
  assign bp_halt  = o_running & i_fetch & ~ext_pend_q & bp_pend_q & ~i_fetch_chained;
  assign do_halt  = ext_halt | bp_halt;

  // external requests wait for the next fetch
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_pend_q  <= 1'b0;
      ext_cause_q <= `EBC_CAUSE_NONE;
    end else if (i_ce) begin
      if (start && !o_running) begin
        ext_pend_q <= 1'b0;
      end else if (ext_halt) begin
        ext_pend_q <= 1'b0;
      end else if (o_running) begin
        // forced break beats trigger when both arrive
        if (i_force_break) begin
          ext_pend_q  <= 1'b1;
          ext_cause_q <= `EBC_CAUSE_FORCED;
        end else if (i_trig_break_en && trig_edge && !ext_pend_q) begin
          ext_pend_q  <= 1'b1;
          ext_cause_q <= `EBC_CAUSE_TRIGGER;
        end
      end
    end
  end

  // breakpoint hit waits for the run to end
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      bp_pend_q <= 1'b0;
    end else if (i_ce) begin
      if (start && !o_running) begin
        bp_pend_q <= 1'b0;
      end else if (do_halt) begin
        bp_pend_q <= 1'b0;
      end else if (any_halt_hit) begin
        bp_pend_q <= 1'b1;
      end
    end
  end

  // run state and halt report
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_running     <= 1'b0;
      o_halt        <= 1'b0;
      o_halt_cause  <= `EBC_CAUSE_NONE;
      o_halt_addr   <= {AW{1'b0}};
      o_resume_addr <= {AW{1'b0}};
      o_pc_start    <= {AW{1'b0}};
      breaks_en_q   <= 1'b0;
    end else if (i_ce) begin
      o_halt <= 1'b0;
      if (start && !o_running) begin
        o_running   <= 1'b1;
        o_pc_start  <= i_start_addr;
        breaks_en_q <= i_run_with_breaks_cmd;
      end else if (do_halt) begin
        o_running   <= 1'b0;
        o_halt      <= 1'b1;
        o_halt_addr <= i_fetch_addr;
        if (ext_halt) begin
          o_halt_cause <= ext_cause_q;
        end else begin
          o_halt_cause <= `EBC_CAUSE_HW_BP;
        end
      end

      // track address past the chained run
      if (o_running && i_fetch && !i_fetch_chained) begin
        o_resume_addr <= i_fetch_addr;
      end
    end
  end

endmodule // ebc_break_ctrl

//--- bench/ebc_trig_src.sv
// external trigger source model
`timescale 1ns/1ps
module ebc_trig_src (
  input  wire logic i_clk,
  input  wire logic i_lvl,
  output logic      o_pin
);
  // pin moves off the sampling edge
  always @(negedge i_clk) o_pin <= i_lvl;
endmodule // ebc_trig_src

//--- bench/ebc_checker.sv
// port assertions of the break control
`timescale 1ns/1ps
module ebc_checker #(parameter AW = 12) (
  input wire          i_clk,
  input wire          i_rst_n,
  input wire          i_force_break,
  input wire          i_trig_pin,
  input wire          i_trig_edge_sel,
  input wire          i_trig_trace_en,
  input wire          i_trig_break_en,
  input wire          i_fetch,
  input wire          i_fetch_chained,
  input wire [AW-1:0] i_fetch_addr,
  input wire          o_running,
  input wire          o_halt,
  input wire [1:0]    o_halt_cause,
  input wire [AW-1:0] o_halt_addr,
  input wire          o_trace_trig
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_force; o_running && i_force_break ##1 i_fetch; endsequence
  sequence s_edge;
    i_trig_trace_en && i_trig_pin == i_trig_edge_sel
    ##1 (i_trig_pin != i_trig_edge_sel && $stable(i_trig_edge_sel) && i_trig_trace_en)[*4];
  endsequence
  sequence s_trig; o_trace_trig && i_trig_break_en && o_running && !i_force_break ##1 i_fetch; endsequence
  property p_hw_unchained; o_halt && o_halt_cause == 2'h1 |-> !$past(i_fetch_chained); endproperty
  property p_halt_addr; o_halt |-> $past(i_fetch) && o_halt_addr == $past(i_fetch_addr); endproperty
  property p_forced; s_force |=> o_halt && o_halt_cause == 2'h2; endproperty
  property p_halt_stops; o_halt |-> !o_running; endproperty
  property p_edge; s_edge |=> ##[0:2] o_trace_trig; endproperty
  property p_trig; s_trig |=> o_halt && o_halt_cause == 2'h3; endproperty
  property p_trace_en; o_trace_trig |-> $past(i_trig_trace_en, 2); endproperty
  property p_pulse; o_trace_trig |=> !o_trace_trig; endproperty
  a_hw_unchained: assert property (p_hw_unchained) else $error("hw halt after chained fetch");
  a_halt_addr: assert property (p_halt_addr) else $error("halt address wrong");
  a_forced: assert property (p_forced) else $error("forced break missed");
  a_halt_stops: assert property (p_halt_stops) else $error("running during halt");
  a_edge: assert property (p_edge) else $error("trace edge missed");
  a_trig: assert property (p_trig) else $error("trigger break missed");
  a_trace_en: assert property (p_trace_en) else $error("trace without enable");
  a_pulse: assert property (p_pulse) else $error("trace pulse too long");
endmodule // ebc_checker
bind ebc_break_ctrl ebc_checker #(.AW(AW)) CHK (.*);

//--- bench/tb_top.sv
// break control testbench
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_run_cmd = 0, i_run_with_breaks_cmd = 0, i_force_break = 0;
  logic i_trig_edge_sel = 1, i_trig_break_en = 1, i_trig_trace_en = 1, i_bp_wr = 0, i_bp_valid = 1;
  logic i_fetch = 0, i_fetch_chained = 0, i_fetch_skipped = 0, lvl = 0, hs, i_trig_pin;
  logic [2:0] i_bp_idx = 0;
  logic [11:0] i_start_addr = 0, i_bp_addr = 0, i_fetch_addr = 0, o_halt_addr, o_resume_addr, o_pc_start;
  logic [7:0] i_bp_count = 0;
  logic o_running, o_halt, o_trace_trig;
  logic [1:0] o_halt_cause;
  int n_errors = 0, total_checks = 0;
  always #50 i_clk = ~i_clk;
  ebc_break_ctrl DUT (.*);
  ebc_trig_src SRC (.i_clk(i_clk), .i_lvl(lvl), .o_pin(i_trig_pin));
  task chk(input logic [11:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task fe(input logic [11:0] a, input logic c, k);
    {i_fetch, i_fetch_addr, i_fetch_chained, i_fetch_skipped} = {1'h1, a, c, k};
    @(negedge i_clk) begin
      hs = o_halt;
      i_fetch = 0;
    end
    @(negedge i_clk);
  endtask
  task st(input logic [11:0] a, input logic b);
    {i_start_addr, i_run_with_breaks_cmd, i_run_cmd} = {a, b, !b};
    @(negedge i_clk) {i_run_with_breaks_cmd, i_run_cmd} = 0;
    @(negedge i_clk) chk(o_pc_start, a);
  endtask
  task bw(input logic [2:0] n, input logic [11:0] a, input logic [7:0] c);
    {i_bp_wr, i_bp_idx, i_bp_addr, i_bp_count} = {1'h1, n, a, c};
    @(negedge i_clk) i_bp_wr = 0;
  endtask
  task t_chain;
    bw(3'h0, 12'h010, 8'h00);
    st(12'h00F, 1'h1);
    fe(12'h010, 1'h0, 1'h0);
    fe(12'h011, 1'h1, 1'h0);
    chk(hs, 1'h0);
    fe(12'h012, 1'h0, 1'h0);
    chk(hs, 1'h1);
    chk(o_halt_addr, 12'h012);
    chk(o_resume_addr, 12'h012);
    chk(o_running, 1'h0);
  endtask
  task t_skip;
    bw(3'h1, 12'h020, 8'h01);
    st(12'h020, 1'h1);
    fe(12'h020, 1'h0, 1'h1);
    fe(12'h020, 1'h0, 1'h0);
    fe(12'h020, 1'h0, 1'h0);
    chk(hs, 1'h0);
    fe(12'h021, 1'h0, 1'h0);
    chk(hs, 1'h1);
  endtask
  task t_force;
    st(12'h040, 1'h0);
    fe(12'h040, 1'h0, 1'h0);
    i_force_break = 1;
    @(negedge i_clk) i_force_break = 0;
    fe(12'h041, 1'h1, 1'h0);
    chk({hs, o_halt_cause}, 3'h6);
    chk(o_running, 1'h0);
    st(12'h043, 1'h0);
  endtask
  task t_trig;
    lvl = 1;
    repeat (8) @(negedge i_clk);
    fe(12'h043, 1'h0, 1'h0);
    chk(hs, 1'h0);
    lvl = 0;
    for (int k = 0; k < 9 && o_trace_trig !== 1'h1; k++) @(negedge i_clk);
    chk(o_trace_trig, 1'h1);
    fe(12'h044, 1'h1, 1'h0);
    chk({hs, o_halt_cause}, 3'h7);
  endtask
  task finish_test;
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst_n = 1;
    t_chain;
    t_skip;
    t_force;
    t_trig;
    finish_test;
  end
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
endmodule // tb_top
